/* File: dv/scc_peer.sv */
// Far-side model of the serial line: sends frames on the receive pin and
// captures preamble, frames, breaks and clock pulses from the transmit pins.
// Assumes a bit time of BIT sys_clk cycles; pins are read 1 ns after edges.
`default_nettype none

module scc_peer #(
  parameter int BIT = 32
) (
  input wire logic clk,
  input wire logic tx_out,
  input wire logic tx_out_en,
  input wire logic sclk_out,
  output var logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line idles high between frames
  initial rx_line = 1'b1;

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // ****************************************
  // Sender
  // ****************************************
  task automatic send(input int nbits, input logic [8:0] d);
    for (int i = 0; i < nbits + 2; i++) begin
      @(posedge clk);
      rx_line <= (i == 0) ? 1'b0 : (i <= nbits) ? d[i-1] : 1'b1;
      repeat (BIT - 1) @(posedge clk);
    end
  endtask

  // ****************************************
  // Capture
  // ****************************************
  task automatic watch_tx(input int nbits, output int pre,
                          output logic [8:0] d, output int clks,
                          output int preclk, output logic pol);
    int c;
    logic prev;
    c = 0;
    pre = 0;
    d = '0;
    clks = 0;
    preclk = 0;
    step();
    while (tx_out_en !== 1'b1 && c < 200 * BIT) begin
      step();
      c++;
    end
    pol = sclk_out;
    prev = pol;
    while (tx_out !== 1'b0 && pre < 40 * BIT) begin
      if (sclk_out !== prev) preclk++;
      prev = sclk_out;
      pre++;
      step();
    end
    for (c = 0; c < (nbits + 2) * BIT; c++) begin
      if (c % BIT == BIT / 2 && c / BIT >= 1 && c / BIT <= nbits)
        d[c/BIT-1] = tx_out;
      if (sclk_out !== prev && prev === pol) clks++;
      prev = sclk_out;
      step();
    end
  endtask

  task automatic low_run(output int n, output int sc);
    int c;
    logic prev;
    n = 0;
    sc = 0;
    c = 0;
    step();
    while (tx_out !== 1'b0 && c < 8 * BIT) begin
      step();
      c++;
    end
    prev = sclk_out;
    while (tx_out === 1'b0 && n < 40 * BIT) begin
      if (sclk_out !== prev) sc++;
      prev = sclk_out;
      n++;
      step();
    end
  endtask

endmodule

`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the serial control block: register port tasks,
// transmit and receive scenarios against the far-side line model.
// Assumes TICK_DIV 2, so one bit is 32 sys_clk cycles.
`default_nettype none

`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
      error_cnt++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

module testbench
  import scc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BIT = 32;
  logic sys_clk;
  logic rst_b;
  scc_bus_req_t bus_req;
  logic [7:0] bus_rdata;
  logic rx_in_pin;
  logic tx_out;
  logic tx_out_en;
  logic sclk_out;
  logic sclk_out_en;
  logic irq_req;
  int error_cnt = 0;
  int num_checks = 0;
  int pre, clks, preclk, n, sc;
  logic [8:0] d;
  logic pol;
  logic [7:0] ien [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h00};
  logic irqx [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  scc_top #(.TICK_DIV(8'h02)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .rx_in_pin(rx_in_pin), .tx_out(tx_out),
    .tx_out_en(tx_out_en), .sclk_out(sclk_out),
    .sclk_out_en(sclk_out_en), .irq_req(irq_req)
  );

  scc_peer #(.BIT(BIT)) peer (
    .clk(sys_clk), .tx_out(tx_out), .tx_out_en(tx_out_en),
    .sclk_out(sclk_out), .rx_line(rx_in_pin)
  );

  // ****************************************
  // Register port tasks
  // ****************************************
  task automatic waitc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e, input string nm);
    logic [7:0] v;
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 v = bus_rdata & m;
    `CHK(nm, e, v)
  endtask

  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst_b = 1'b0;
    bus_req = '0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(ADDR_LFC, 8'hff, LFC_RESET, "lfc");
    rdc(ADDR_FEC, 8'hff, FEC_RESET, "fec");
    rdc(ADDR_SR, 8'hff, 8'hc0, "status");
    rdc(8'h20, 8'hff, 8'h00, "unmapped");
    wr(ADDR_LFC, 8'hff);
    rdc(ADDR_LFC, 8'hff, 8'h5f, "lfc_ro");
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_FEC, ien[i]);
      waitc(3);
      `CHK("irq", irqx[i], irq_req)
    end
    // Clock options settle before the transmitter is enabled
    wr(ADDR_LFC, 8'h06);
    rdc(ADDR_SR, 8'h80, 8'h80, "tx_holding_empty");
    wr(ADDR_DR, 8'h3c);
    wr(ADDR_FEC, 8'h08);
    peer.watch_tx(8, pre, d, clks, preclk, pol);
    `CHK("idle_lvl", 1'b1, pol)
    `CHK("pre_bits", 10, (pre + BIT / 2) / BIT)
    `CHK("pre_clk", 0, preclk)
    `CHK("data8", 8'h3c, d[7:0])
    `CHK("clks8", 7, clks)
    `CHK("sclk_en", 1'b1, sclk_out_en)
    // Final byte then gate cleared mid-frame
    rdc(ADDR_SR, 8'h80, 8'h80, "tdre2");
    wr(ADDR_DR, 8'h81);
    fork
      peer.watch_tx(8, pre, d, clks, preclk, pol);
      begin
        waitc(5 * BIT);
        wr(ADDR_FEC, 8'h00);
      end
    join
    `CHK("last", 8'h81, d[7:0])
    waitc(2 * BIT);
    `CHK("released", 1'b0, tx_out_en)
    wr(ADDR_LFC, 8'h51);
    rdc(ADDR_SR, 8'h80, 8'h80, "tdre3");
    wr(ADDR_DR, 8'ha3);
    wr(ADDR_FEC, 8'h08);
    peer.watch_tx(9, pre, d, clks, preclk, pol);
    `CHK("idle_lvl9", 1'b0, pol)
    `CHK("pre_bits9", 11, (pre + BIT / 2) / BIT)
    `CHK("data9", 9'h1a3, d)
    `CHK("clks9", 9, clks)
    wr(ADDR_FEC, 8'h09);
    wr(ADDR_FEC, 8'h08);
    peer.low_run(n, sc);
    `CHK("brk_bits", 11, (n + BIT / 2) / BIT)
    `CHK("brk_clk", 0, sc)
    // Gate dropped and raised mid-byte: byte, new preamble, next byte
    rdc(ADDR_SR, 8'h80, 8'h80, "tdre4");
    wr(ADDR_DR, 8'h5a);
    fork
      peer.watch_tx(9, pre, d, clks, preclk, pol);
      begin
        waitc(5 * BIT);
        wr(ADDR_FEC, 8'h00);
        wr(ADDR_FEC, 8'h08);
        rdc(ADDR_SR, 8'h80, 8'h80, "tdre5");
        wr(ADDR_DR, 8'h66);
      end
    join
    `CHK("re_first", 9'h15a, d)
    peer.watch_tx(9, pre, d, clks, preclk, pol);
    `CHK("re_pre", 11, (pre + BIT / 2) / BIT)
    `CHK("re_data", 9'h166, d)
    wr(ADDR_FEC, 8'h00);
    waitc(3 * BIT);
    // Receive a nine-bit frame
    wr(ADDR_LFC, 8'h10);
    wr(ADDR_FEC, 8'h04);
    peer.send(9, 9'h1c7);
    waitc(12 * BIT);
    rdc(ADDR_LFC, 8'h80, 8'h80, "rx9");
    rdc(ADDR_SR, 8'h26, 8'h20, "rx_full");
    rdc(ADDR_DR, 8'hff, 8'hc7, "rx_data");
    rdc(ADDR_SR, 8'h3e, 8'h00, "rx_clr");
    wr(ADDR_FEC, 8'h00);
    peer.send(9, 9'h055);
    waitc(2 * BIT);
    rdc(ADDR_SR, 8'h3e, 8'h00, "gated");
    wr(ADDR_LFC, 8'h00);
    wr(ADDR_FEC, 8'h04);
    waitc(11 * BIT);
    wr(ADDR_FEC, 8'h06);
    rdc(ADDR_FEC, 8'hff, 8'h04, "no_sleep");
    wr(ADDR_LFC, 8'h08);
    wr(ADDR_FEC, 8'h06);
    rdc(ADDR_FEC, 8'hff, 8'h06, "sleep");
    peer.send(8, 9'h015);
    waitc(2 * BIT);
    rdc(ADDR_SR, 8'h3e, 8'h00, "asleep");
    rdc(ADDR_FEC, 8'h02, 8'h02, "still");
    peer.send(8, 9'h095);
    waitc(2 * BIT);
    rdc(ADDR_FEC, 8'h02, 8'h00, "woke");
    rdc(ADDR_SR, 8'h20, 8'h20, "addr_full");
    rdc(ADDR_DR, 8'hff, 8'h95, "addr");
    // Idle-line wake from sleep, no idle flag while asleep
    wr(ADDR_LFC, 8'h00);
    wr(ADDR_FEC, 8'h06);
    rdc(ADDR_FEC, 8'h02, 8'h02, "idle_sleep");
    waitc(11 * BIT);
    rdc(ADDR_FEC, 8'h02, 8'h00, "idle_wake");
    rdc(ADDR_SR, 8'h10, 8'h00, "no_idle_flag");
    wrap_up();
  end

endmodule

`default_nettype wire

/* File: rtl/scc_pkg.sv */
// Package for the serial control block: register map, field layouts,
// reset values, bit timing and state encodings.
// Assumes an 8-bit register port and a 16x sample tick.
`default_nettype none

package scc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_LFC = 8'h0e;
  localparam logic [7:0] ADDR_FEC = 8'h0f;
  localparam logic [7:0] ADDR_SR = 8'h10;
  localparam logic [7:0] ADDR_DR = 8'h11;
  localparam logic [7:0] LFC_RESET = 8'h00;
  localparam logic [7:0] FEC_RESET = 8'h00;

  // ****************************************
  // Bit timing
  // ****************************************
  localparam logic [3:0] FRAME_BASE = 4'ha;
  localparam logic [3:0] DATA_BASE = 4'h8;
  localparam logic [3:0] TICK_S1 = 4'h7;
  localparam logic [3:0] TICK_S2 = 4'h8;
  localparam logic [3:0] TICK_S3 = 4'h9;
  localparam logic [3:0] TICK_HALF = 4'h8;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] MARK_LEN = 4'h1;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic rx_ninth_bit;
    logic tx_ninth_bit;
    logic rsv;
    logic char_length_select;
    logic rouse_method_select;
    logic sclk_idle_level;
    logic sclk_phase_select;
    logic last_bit_clock_enable;
  } scc_lfc_t;

  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_full_irq_en;
    logic idle_line_irq_en;
    logic tx_gate;
    logic rx_gate;
    logic rx_sleep;
    logic break_send;
  } scc_fec_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scc_bus_req_t;

  typedef enum logic [2:0] {
    TX_OFF = 3'b000,
    TX_MARK = 3'b001,
    TX_PRE = 3'b010,
    TX_BRK = 3'b011,
    TX_DATA = 3'b100
  } scc_tx_st_t;

  typedef enum logic [0:0] {
    RX_WAIT = 1'b0,
    RX_RUN = 1'b1
  } scc_rx_st_t;

  localparam logic [1:0] SYNC_RESET = 2'h3;

endpackage

`default_nettype wire

/* File: rtl/scc_tick.sv */
// Receive pin synchroniser and 16x sample tick divider.
// Assumes the pin is asynchronous to sys_clk.
`default_nettype none

module scc_tick
  import scc_pkg::*;
#(
  parameter logic [7:0] TICK_DIV = 8'h1a
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic rx_in_pin,
  output logic rx_line,
  output logic sample_tick
);

  typedef struct packed {
    logic [1:0] sync;
    logic [7:0] cnt;
    logic tick;
  } scc_tick_state_t;

  scc_tick_state_t q;
  scc_tick_state_t d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.sync = {q.sync[0], rx_in_pin};
    d.tick = 1'b0;
    if (q.cnt == TICK_DIV - 8'h01) begin
      d.cnt = 8'h00;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.sync <= SYNC_RESET;
    end else begin
      q <= d;
    end
  end

  assign rx_line = q.sync[1];
  assign sample_tick = q.tick;

endmodule

`default_nettype wire

/* File: rtl/scc_top.sv */
// Serial control block: format and enable registers, transmitter with
// preamble, break and synchronous clock output, receiver with wake-up.
// Assumes a one-cycle register port and an asynchronous receive pin.
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none

module scc_top
  import scc_pkg::*;
#(
  parameter logic [7:0] TICK_DIV = 8'h1a
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire scc_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic rx_in_pin,
  output logic tx_out,
  output logic tx_out_en,
  output logic sclk_out,
  output logic sclk_out_en,
  output logic irq_req
);

  typedef struct packed {
    scc_lfc_t lfc;
    scc_fec_t fec;
    logic [7:0] tx_hold;
    logic [7:0] rx_hold;
    logic tx_holding_empty;
    logic tx_done;
    logic rx_holding_full;
    logic line_quiet_flag;
    logic overrun;
    logic noise_flag;
    logic framing_error_flag;
    logic tx_arm;
    logic rx_arm;
    logic idle_armed;
    logic line_idle;
    scc_tx_st_t tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_idx;
    logic [3:0] tx_len;
    logic [3:0] tx_tick;
    logic gate_prev;
    logic brk_prev;
    logic pre_pend;
    logic brk_pend;
    logic post_brk;
    scc_rx_st_t rx_st;
    logic [3:0] rx_tick;
    logic [3:0] rx_idx;
    logic [8:0] rx_sh;
    logic [1:0] rx_smp;
    logic rx_noise;
    logic [7:0] idle_cnt;
    logic [7:0] rdata;
    logic txd;
    logic txen;
    logic sclk;
    logic irq;
  } scc_state_t;

  scc_state_t q;
  scc_state_t d;

  logic rx_line;
  logic tick;
  logic m9;
  logic [3:0] flen;
  logic [3:0] nbits;
  logic sr_rd;
  logic dr_rd;
  logic dr_wr;
  logic gate_rise;
  logic pre_now;
  logic brk_now;
  logic tx_edge;
  logic clk_on;
  logic half1;
  logic maj;
  logic noisy;
  logic take;
  scc_lfc_t wl;
  scc_fec_t wf;

  // Frame length in bits: start, data, stop
  function automatic logic [3:0] frame_len(input logic nine);
    return FRAME_BASE + {3'h0, nine};
  endfunction

  scc_tick #(
    .TICK_DIV(TICK_DIV)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .rx_in_pin(rx_in_pin),
    .rx_line(rx_line),
    .sample_tick(tick)
  );

  assign m9 = q.lfc.char_length_select;
  assign flen = frame_len(m9);
  assign nbits = DATA_BASE + {3'h0, m9};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    wl = scc_lfc_t'(bus_req.wdata);
    wf = scc_fec_t'(bus_req.wdata);
    sr_rd = bus_req.rd && (bus_req.addr == ADDR_SR);
    dr_rd = bus_req.rd && (bus_req.addr == ADDR_DR);
    dr_wr = bus_req.wr && (bus_req.addr == ADDR_DR);
    gate_rise = q.fec.tx_gate && !q.gate_prev;
    pre_now = q.pre_pend || gate_rise;
    brk_now = q.brk_pend || q.fec.break_send;
    tx_edge = tick && (q.tx_st == TX_OFF || q.tx_tick == TICK_LAST);
    maj = 1'b0;
    noisy = 1'b0;
    take = 1'b0;

    // Register reads, data valid for one cycle
    d.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_LFC: d.rdata = q.lfc;
        ADDR_FEC: d.rdata = q.fec;
        ADDR_SR: d.rdata = {q.tx_holding_empty, q.tx_done,
          q.rx_holding_full, q.line_quiet_flag, q.overrun,
          q.noise_flag, q.framing_error_flag, 1'b0};
        ADDR_DR: d.rdata = q.rx_hold;
        default: d.rdata = 8'h00;
      endcase
    end

    // Status read arms the flag clears
    if (sr_rd) begin
      d.tx_arm = q.tx_holding_empty || q.tx_done;
      d.rx_arm = q.rx_holding_full || q.line_quiet_flag || q.overrun ||
        q.noise_flag || q.framing_error_flag;
    end
    if (dr_wr) begin
      d.tx_hold = bus_req.wdata;
      d.tx_arm = 1'b0;
      if (q.tx_arm) begin
        d.tx_holding_empty = 1'b0;
        d.tx_done = 1'b0;
      end
    end
    if (dr_rd && q.rx_arm) begin
      d.rx_arm = 1'b0;
      d.rx_holding_full = 1'b0;
      d.line_quiet_flag = 1'b0;
      d.overrun = 1'b0;
      d.noise_flag = 1'b0;
      d.framing_error_flag = 1'b0;
    end

    // Register writes
    if (bus_req.wr && bus_req.addr == ADDR_LFC) begin
      d.lfc.tx_ninth_bit = wl.tx_ninth_bit;
      d.lfc.char_length_select = wl.char_length_select;
      d.lfc.rouse_method_select = wl.rouse_method_select;
      d.lfc.sclk_idle_level = wl.sclk_idle_level;
      d.lfc.sclk_phase_select = wl.sclk_phase_select;
      d.lfc.last_bit_clock_enable = wl.last_bit_clock_enable;
    end
    if (bus_req.wr && bus_req.addr == ADDR_FEC) begin
      d.fec = wf;
      if (wf.rx_sleep && !q.fec.rx_sleep && q.line_idle &&
          !q.lfc.rouse_method_select) begin
        d.fec.rx_sleep = 1'b0;
      end
    end

    // ****************************************
    // Transmitter
    // ****************************************
    d.gate_prev = q.fec.tx_gate;
    d.brk_prev = q.fec.break_send;
    if (gate_rise) begin
      d.pre_pend = 1'b1;
    end
    if (q.fec.break_send && !q.brk_prev) begin
      d.brk_pend = 1'b1;
    end
    if (tick) begin
      d.tx_tick = (q.tx_st == TX_OFF) ? 4'h0 : q.tx_tick + 4'h1;
    end
    if (tx_edge) begin
      if (q.tx_idx + 4'h1 < q.tx_len) begin
        d.tx_idx = q.tx_idx + 4'h1;
        d.tx_sh = {1'b1, q.tx_sh[10:1]};
      end else begin
        d.tx_idx = 4'h0;
        d.tx_tick = 4'h0;
        d.tx_len = flen;
        d.tx_sh = '1;
        if (!q.fec.tx_gate) begin
          d.tx_st = TX_OFF;
          d.tx_len = MARK_LEN;
        end else if (pre_now) begin
          d.tx_st = TX_PRE;
          d.pre_pend = 1'b0;
        end else if (brk_now) begin
          d.tx_st = TX_BRK;
          d.tx_sh = '0;
          d.brk_pend = 1'b0;
          d.post_brk = 1'b1;
        end else if (q.post_brk) begin
          d.tx_st = TX_MARK;
          d.tx_len = MARK_LEN;
          d.post_brk = 1'b0;
        end else if (!d.tx_holding_empty) begin
          d.tx_st = TX_DATA;
          d.tx_sh = {1'b1, m9 ? q.lfc.tx_ninth_bit : 1'b1,
            q.tx_hold, 1'b0};
          d.tx_holding_empty = 1'b1;
        end else begin
          d.tx_st = TX_MARK;
          d.tx_len = MARK_LEN;
          d.tx_done = 1'b1;
        end
      end
    end

    // Pins follow the shifter; clock only on data bits
    d.txen = (q.tx_st != TX_OFF);
    d.txd = q.tx_sh[0];
    clk_on = (q.tx_st == TX_DATA) && (q.tx_idx != 4'h0) &&
      (q.tx_idx < nbits ||
      (q.tx_idx == nbits && q.lfc.last_bit_clock_enable));
    half1 = q.tx_tick < TICK_HALF;
    d.sclk = q.lfc.sclk_idle_level ^ (clk_on &&
      (q.lfc.sclk_phase_select ? half1 : !half1));

    // ****************************************
    // Receiver
    // ****************************************
    if (!q.fec.rx_gate) begin
      d.rx_st = RX_WAIT;
      d.idle_cnt = 8'h00;
      d.line_idle = 1'b0;
    end else if (tick && q.rx_st == RX_WAIT) begin
      if (!rx_line) begin
        d.rx_st = RX_RUN;
        d.rx_tick = 4'h0;
        d.rx_idx = 4'h0;
        d.rx_noise = 1'b0;
        d.idle_cnt = 8'h00;
        d.line_idle = 1'b0;
      end else if (!q.line_idle) begin
        if (q.idle_cnt + 8'h01 == {flen, 4'h0}) begin
          d.line_idle = 1'b1;
          if (q.fec.rx_sleep) begin
            if (!q.lfc.rouse_method_select) begin
              d.fec.rx_sleep = 1'b0;
            end
          end else if (q.idle_armed) begin
            d.line_quiet_flag = 1'b1;
            d.idle_armed = 1'b0;
          end
        end else begin
          d.idle_cnt = q.idle_cnt + 8'h01;
        end
      end
    end else if (tick) begin
      d.rx_tick = q.rx_tick + 4'h1;
      if (q.rx_tick == TICK_LAST) begin
        d.rx_idx = q.rx_idx + 4'h1;
      end
      if (q.rx_tick == TICK_S1) begin
        d.rx_smp[0] = rx_line;
      end
      if (q.rx_tick == TICK_S2) begin
        d.rx_smp[1] = rx_line;
      end
      if (q.rx_tick == TICK_S3) begin
        maj = (q.rx_smp[0] & q.rx_smp[1]) | (q.rx_smp[0] & rx_line) |
          (q.rx_smp[1] & rx_line);
        noisy = (q.rx_smp[0] != q.rx_smp[1]) || (q.rx_smp[1] != rx_line);
        d.rx_noise = q.rx_noise || noisy;
        if (q.rx_idx == 4'h0) begin
          if (maj) begin
            d.rx_st = RX_WAIT;
          end
        end else if (q.rx_idx <= nbits) begin
          d.rx_sh = {maj, q.rx_sh[8:1]};
        end else begin
          d.rx_st = RX_WAIT;
          take = !q.fec.rx_sleep ||
            (q.lfc.rouse_method_select && q.rx_sh[8]);
          if (q.fec.rx_sleep && take) begin
            d.fec.rx_sleep = 1'b0;
          end
          if (take && d.rx_holding_full) begin
            d.overrun = 1'b1;
          end else if (take && !d.framing_error_flag) begin
            d.rx_holding_full = 1'b1;
            d.rx_hold = m9 ? q.rx_sh[7:0] : q.rx_sh[8:1];
            d.lfc.rx_ninth_bit = m9 & q.rx_sh[8];
            d.noise_flag = q.rx_noise || noisy;
            d.framing_error_flag = !maj;
            d.idle_armed = 1'b1;
          end
        end
      end
    end

    d.irq = (q.fec.tx_empty_irq_en && q.tx_holding_empty) ||
      (q.fec.tx_done_irq_en && q.tx_done) ||
      (q.fec.rx_full_irq_en && (q.rx_holding_full || q.overrun)) ||
      (q.fec.idle_line_irq_en && q.line_quiet_flag);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.lfc <= scc_lfc_t'(LFC_RESET);
      q.fec <= scc_fec_t'(FEC_RESET);
      q.tx_holding_empty <= 1'b1;
      q.tx_done <= 1'b1;
      q.txd <= 1'b1;
      q.tx_sh <= '1;
    end else begin
      q <= d;
    end
  end

  assign bus_rdata = q.rdata;
  assign tx_out = q.txd;
  assign tx_out_en = q.txen;
  assign sclk_out = q.sclk;
  assign sclk_out_en = q.txen;
  assign irq_req = q.irq;

  // ****************************************
  // Checks
  // ****************************************
  property p_rest_level;
    @(posedge sys_clk) disable iff (!rst_b)
    (q.tx_st != TX_DATA) |=> (sclk_out == $past(q.lfc.sclk_idle_level));
  endproperty
  a_rest_level: assert property (p_rest_level)
    else $error("clock pin not at rest level");

  property p_early_edge;
    @(posedge sys_clk) disable iff (!rst_b)
    (q.tx_st == TX_DATA && q.tx_idx == 4'h1 && q.tx_tick == 4'h0 &&
      q.lfc.sclk_phase_select) |=>
      (sclk_out != $past(q.lfc.sclk_idle_level));
  endproperty
  a_early_edge: assert property (p_early_edge)
    else $error("clock edge missing at bit start");

  property p_last_bit;
    @(posedge sys_clk) disable iff (!rst_b)
    (q.tx_st == TX_DATA && q.tx_idx == nbits &&
      !q.lfc.last_bit_clock_enable) |=>
      (sclk_out == $past(q.lfc.sclk_idle_level));
  endproperty
  a_last_bit: assert property (p_last_bit)
    else $error("last bit clocked while disabled");

  property p_preamble;
    @(posedge sys_clk) disable iff (!rst_b)
    (q.tx_st == TX_PRE) |=> (tx_out && tx_out_en);
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("preamble bit not high");

  property p_finish_byte;
    @(posedge sys_clk) disable iff (!rst_b)
    (q.tx_st == TX_DATA && !q.fec.tx_gate && !tx_edge) |=>
      tx_out_en [*2];
  endproperty
  a_finish_byte: assert property (p_finish_byte)
    else $error("pins released mid byte");

  property p_break_low;
    @(posedge sys_clk) disable iff (!rst_b)
    (q.tx_st == TX_BRK) |=> !tx_out;
  endproperty
  a_break_low: assert property (p_break_low)
    else $error("break bit not low");

  property p_rx_off;
    @(posedge sys_clk) disable iff (!rst_b)
    (!q.fec.rx_gate && !q.rx_holding_full && !q.overrun) |=>
      (!q.rx_holding_full && !q.overrun);
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("receiver flag set while disabled");

  property p_sleep_quiet;
    @(posedge sys_clk) disable iff (!rst_b)
    (q.fec.rx_sleep && !q.line_quiet_flag) |=> !q.line_quiet_flag;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("idle flag set while asleep");

  property p_irq_gate;
    @(posedge sys_clk) disable iff (!rst_b)
    (q.fec[7:4] == 4'h0) |=> !irq_req;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt with all sources disabled");

  property p_empty_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    (q.tx_holding_empty && !q.tx_arm && dr_wr) |=> q.tx_holding_empty;
  endproperty
  a_empty_hold: assert property (p_empty_hold)
    else $error("empty flag cleared without status read");

endmodule

`default_nettype wire
